// ==== logic/uec_endpoint_control.sv ====
// APB register block holding per-endpoint control bits for the USB device endpoints.
// Behaviour
// R1: Set bit 24 marks bank 0 busy so non-SETUP traffic gets NAK; clear removes.
// R2: Set bit 25 marks bank 1 busy likewise until its clear bit is written.
// R3: Halt request set by software, cleared by new SETUP or clear register.
// R4: Toggle-clear set bit resets data toggle so next packet uses DATA0.
// R5: Toggle-clear bit position always reads zero.
// R6: On control endpoints handoff and write-allowed bits read zero; software avoids them.
// R7: On IN endpoints, clearing handoff releases current bank for transmit, next bank.
// R8: On IN endpoints hardware sets handoff with the IN-bank-free flag.
// R9: On OUT endpoints, clearing handoff frees the current bank and advances.
// R10: On OUT endpoints hardware sets handoff with the received-data flag.
// R11: Discard set starts killing last written IN bank; hardware clears when done.
// R12: Software waits for discard flag zero before preparing another IN packet.
// R13: A real discard decrements the busy-bank count.
// R14: A bank sent instead of discarded decrements count and sets IN-bank-free.
// R15: With two banks ready, send the first and discard only the last.
// R16: Busy-bank-count interrupt enable at bit 12, set and cleared, gates that interrupt.
// R17: RAM fault interrupt enable at bit 11, set or cleared by writing one.
// R18: Low-byte enables at bits 0,1,2,3,4,6; bits 2 and 6 differ on isochronous.
// R19: A one written to the clear register clears the same control bit.
// R20: A one written to the set register sets the same control bit.
// R21: Zero bits written to set or clear leave control bits unchanged.
// R22: Each event flag raises endpoint interrupt only while its enable bit is one.
// R23: Registers replicated for endpoints zero to six at four-byte steps.
`include "uec_defines.svh"

module uec_endpoint_control #(
	parameter int NUM_EP = 7
) (
	// Clock and reset.
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave.
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Endpoint configuration and engine events.
	input  wire uec_pkg::uec_ep_type_t     ep_type     [NUM_EP],
	input  wire logic [NUM_EP-1:0]         ep_is_in,
	input  wire logic [1:0]                ready_banks [NUM_EP],
	input  wire uec_pkg::uec_evt_t         ep_evt      [NUM_EP],
	// Commands toward the engine.
	output uec_pkg::uec_cmd_t              ep_cmd      [NUM_EP]
);
	import uec_pkg::*;

	// The address decode and the three-bit endpoint index serve at most seven endpoints.
	generate
		if (NUM_EP < 1 || NUM_EP > 7) begin : g_bad_ep
			$error("NUM_EP must be 1 to 7");
		end
	endgenerate

	typedef struct packed {
		logic [NUM_EP-1:0][31:0] ctrl;
		logic [NUM_EP-1:0][8:0]  cmd;
		logic [31:0]             rdata;
		logic                    ready;
		logic                    err;
	} uec_state_t;

	uec_state_t st_q;
	uec_state_t st_d;

	localparam logic [11:0] SPAN = 12'(NUM_EP * 4);

	// Returns 1 when the address falls in a bank of per-endpoint registers.
	function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
		in_bank = (a >= base) && (a < base + SPAN) && (a[1:0] == 2'b00);
	endfunction

	// Register bank that one setup address selects.
	typedef enum logic [2:0] {
		UEC_SEL_NONE,
		UEC_SEL_CTRL,
		UEC_SEL_SET,
		UEC_SEL_CLR,
		UEC_SEL_STAT
	} uec_sel_t;

	function automatic uec_sel_t sel_of(input logic [11:0] a);
		uec_sel_t s;
		if (in_bank(a, `UEC_CTRL_BASE)) begin
			s = UEC_SEL_CTRL;
		end else if (in_bank(a, `UEC_SET_BASE)) begin
			s = UEC_SEL_SET;
		end else if (in_bank(a, `UEC_CLR_BASE)) begin
			s = UEC_SEL_CLR;
		end else if (in_bank(a, `UEC_STAT_BASE)) begin
			s = UEC_SEL_STAT;
		end else begin
			s = UEC_SEL_NONE;
		end
		sel_of = s;
	endfunction

	// Endpoint number of a word inside one register bank.
	function automatic logic [2:0] ep_of(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] off;
		off = a - base;
		ep_of = off[4:2];
	endfunction

	// Byte lanes of pwdata that a write may touch.
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		lane_mask = m;
	endfunction

	// Control word after a set write; zero bits and unsettable bits are left alone.
	function automatic logic [31:0] set_word(
		input logic [31:0] cur,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		set_word = cur | (data & lane_mask(strb) & `UEC_SET_MASK & `UEC_CTRL_MASK);
	endfunction

	// Control word after a clear write; the discard flag is outside the clear mask.
	function automatic logic [31:0] clr_word(
		input logic [31:0] cur,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		clr_word = cur & ~(data & lane_mask(strb) & `UEC_CLR_MASK);
	endfunction

	// Software view of a control word: command bits read zero, and the handoff bit
	// reads zero on control endpoints because it has no meaning there.
	function automatic logic [31:0] read_word(
		input logic [31:0] cur,
		input logic        is_control
	);
		logic [31:0] v;
		v = cur & `UEC_CTRL_MASK;
		v[`UEC_B_TOG_CLR] = 1'b0;
		if (is_control) begin
			v[`UEC_B_HANDOFF] = 1'b0;
		end
		read_word = v;
	endfunction

	// Endpoint interrupt: each event flag only counts while its enable is one.
	function automatic logic irq_of(input logic [6:0] flags, input logic [31:0] cur);
		logic hit;
		hit = 1'b0;
		hit = hit | (flags[0] & cur[`UEC_B_IN_FREE]);
		hit = hit | (flags[1] & cur[`UEC_B_OUT_ARR]);
		hit = hit | (flags[2] & cur[`UEC_B_SETUP_ERR]);
		hit = hit | (flags[3] & cur[`UEC_B_NAK_OUT]);
		hit = hit | (flags[4] & cur[`UEC_B_NAK_IN]);
		hit = hit | (flags[5] & cur[`UEC_B_OCC_CNT]);
		hit = hit | (flags[6] & cur[`UEC_B_HALTED]);
		irq_of = hit;
	endfunction

	// Hardware handoff set: a free IN bank, a bank sent during a discard, or a full OUT bank.
	function automatic logic handoff_evt(input logic is_in, input uec_evt_t ev);
		logic hit;
		if (is_in) begin
			hit = ev.in_bank_free || ev.discard_sent; // R8 R14
		end else begin
			hit = ev.out_bank_full; // R10
		end
		handoff_evt = hit;
	endfunction

	logic        acc;
	logic [2:0]  idx;
	uec_sel_t    sel;

	always_comb begin
		st_d = st_q;
		acc = psel && !penable;
		idx = 3'h0;
		sel = sel_of(paddr);
		st_d.ready = 1'b0;
		st_d.err = 1'b0;
		for (int e = 0; e < NUM_EP; e++) begin
			st_d.cmd[e] = 9'h000;
		end
		// Engine events; software set and clear writes below override these hardware clears.
		for (int e = 0; e < NUM_EP; e++) begin
			if (ep_evt[e].setup_rx) begin
				st_d.ctrl[e][`UEC_B_HALT_REQ] = 1'b0; // R3
			end
			if (ep_evt[e].discard_done || ep_evt[e].discard_sent) begin
				st_d.ctrl[e][`UEC_B_DISCARD] = 1'b0; // R11
				st_d.cmd[e][2] = 1'b1; // R13 R14
			end
			if (ep_evt[e].discard_sent) begin
				st_d.cmd[e][1] = 1'b1; // R14
			end
		end
		// Setup phase decode; answer comes in the following access cycle.
		if (acc) begin
			st_d.ready = 1'b1;
			st_d.rdata = 32'h00000000;
			if (sel == UEC_SEL_CTRL) begin
				idx = ep_of(paddr, `UEC_CTRL_BASE); // R23
				if (!pwrite) begin
					st_d.rdata = read_word(st_q.ctrl[idx], ep_type[idx] == UEC_EP_CONTROL); // R5 R6
				end else begin
					st_d.err = 1'b1;
				end
			end else if (sel == UEC_SEL_SET) begin
				idx = ep_of(paddr, `UEC_SET_BASE); // R23
				if (pwrite) begin
					st_d.ctrl[idx] = set_word(st_d.ctrl[idx], pwdata, pstrb); // R20 R21 R1 R2 R16 R17 R18
					if (pwdata[`UEC_B_TOG_CLR] && pstrb[2]) begin
						st_d.cmd[idx][5] = 1'b1; // R4
					end
					if (pwdata[`UEC_B_DISCARD] && pstrb[1] && ep_is_in[idx]) begin
						st_d.cmd[idx][3] = 1'b1; // R11 R15
					end
				end
			end else if (sel == UEC_SEL_CLR) begin
				idx = ep_of(paddr, `UEC_CLR_BASE); // R23
				if (pwrite) begin
					if (pwdata[`UEC_B_HANDOFF] && pstrb[1] && ep_type[idx] != UEC_EP_CONTROL
						&& st_q.ctrl[idx][`UEC_B_HANDOFF]) begin
						st_d.cmd[idx][4] = 1'b1; // R7 R9
					end
					st_d.ctrl[idx] = clr_word(st_d.ctrl[idx], pwdata, pstrb); // R19 R21
				end
			end else if (sel == UEC_SEL_STAT) begin
				idx = ep_of(paddr, `UEC_STAT_BASE);
				if (!pwrite) begin
					st_d.rdata = {25'h0000000, ep_evt[idx].event_flags};
				end
			end else begin
				st_d.err = 1'b1;
			end
		end
		// Hardware handoff set applied last so it wins over a simultaneous clear.
		for (int e = 0; e < NUM_EP; e++) begin
			if (ep_type[e] != UEC_EP_CONTROL) begin
				if (handoff_evt(ep_is_in[e], ep_evt[e])) begin
					st_d.ctrl[e][`UEC_B_HANDOFF] = 1'b1; // R8 R10
				end
			end else begin
				st_d.ctrl[e][`UEC_B_HANDOFF] = 1'b0; // R6
			end
			if (st_d.cmd[e][3] && ready_banks[e] != 2'h0) begin
				st_d.ctrl[e][`UEC_B_DISCARD] = 1'b1; // R11
			end
			if (st_d.cmd[e][3] && ready_banks[e] == 2'h0) begin
				st_d.cmd[e][3] = 1'b0;
			end
			st_d.ctrl[e][`UEC_B_TOG_CLR] = 1'b0; // R5
			// Levels mirror the control bits one cycle after they change.
			st_d.cmd[e][8] = st_q.ctrl[e][`UEC_B_HOLD0]; // R1
			st_d.cmd[e][7] = st_q.ctrl[e][`UEC_B_HOLD1]; // R2
			st_d.cmd[e][6] = st_q.ctrl[e][`UEC_B_HALT_REQ]; // R3
			st_d.cmd[e][0] = irq_of(ep_evt[e].event_flags, st_q.ctrl[e]); // R22 R16
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata  = st_q.rdata;
	assign pready  = st_q.ready;
	assign pslverr = st_q.err;

	// The discard request is only forwarded when a bank is ready; the engine picks the last one.
	generate
		for (genvar g = 0; g < NUM_EP; g++) begin : g_cmd
			assign ep_cmd[g].hold0         = st_q.cmd[g][8]; // R1
			assign ep_cmd[g].hold1         = st_q.cmd[g][7]; // R2
			assign ep_cmd[g].halt_req      = st_q.cmd[g][6]; // R3
			assign ep_cmd[g].toggle_clear  = st_q.cmd[g][5]; // R4
			assign ep_cmd[g].release_bank  = st_q.cmd[g][4]; // R7 R9
			assign ep_cmd[g].discard_start = st_q.cmd[g][3]; // R11 R15
			assign ep_cmd[g].count_dec     = st_q.cmd[g][2]; // R13
			assign ep_cmd[g].in_free_set   = st_q.cmd[g][1]; // R14
			assign ep_cmd[g].irq           = st_q.cmd[g][0]; // R22
		end
	endgenerate
endmodule

// ==== logic/uec_defines.svh ====
// Register offsets, field positions and reset values for the endpoint control block.
`ifndef UEC_DEFINES_SVH
`define UEC_DEFINES_SVH

`define UEC_CTRL_BASE     12'h1C0
`define UEC_SET_BASE      12'h1F0
`define UEC_CLR_BASE      12'h220
`define UEC_STAT_BASE     12'h250
`define UEC_EP_STRIDE     12'h004
`define UEC_CTRL_RESET    32'h00000000

`define UEC_B_IN_FREE     0
`define UEC_B_OUT_ARR     1
`define UEC_B_SETUP_ERR   2
`define UEC_B_NAK_OUT     3
`define UEC_B_NAK_IN      4
`define UEC_B_HALTED      6
`define UEC_B_RAM_FAULT   11
`define UEC_B_OCC_CNT     12
`define UEC_B_DISCARD     13
`define UEC_B_HANDOFF     14
`define UEC_B_TOG_CLR     18
`define UEC_B_HALT_REQ    19
`define UEC_B_HOLD0       24
`define UEC_B_HOLD1       25

// Bits that hold state: enables, discard, handoff, halt request and both holds.
`define UEC_CTRL_MASK     32'h0308785F
// Bits software may clear; the discard flag is cleared by hardware only.
`define UEC_CLR_MASK      32'h0308585F
// Bits software may set; handoff is set by hardware, discard only when a bank can be dropped.
`define UEC_SET_MASK      32'h030C185F

`endif

// ==== logic/uec_pkg.sv ====
// Types shared by the endpoint control block.
package uec_pkg;
	typedef enum logic [1:0] {
		UEC_EP_CONTROL,
		UEC_EP_ISO,
		UEC_EP_BULK,
		UEC_EP_INTR
	} uec_ep_type_t;

	// Events from the USB engine, one struct per endpoint.
	typedef struct packed {
		logic setup_rx;
		logic in_bank_free;
		logic out_bank_full;
		logic discard_done;
		logic discard_sent;
		logic [6:0] event_flags;
	} uec_evt_t;

	// Per-endpoint commands to the USB engine, all one-cycle pulses except the levels hold0, hold1, halt_req and irq.
	typedef struct packed {
		logic hold0;
		logic hold1;
		logic halt_req;
		logic toggle_clear;
		logic release_bank;
		logic discard_start;
		logic count_dec;
		logic in_free_set;
		logic irq;
	} uec_cmd_t;
endpackage

// ==== testbench/uec_properties.sv ====
// Port-level checks for the endpoint control block.
`include "uec_defines.svh"
module uec_properties
	import uec_pkg::*;
#(parameter int NUM_EP = 7) (
	// Clock and reset.
	input wire logic          pclk,
	input wire logic          presetn,
	// APB slave.
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [3:0]    pstrb,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	// Engine side.
	input wire uec_ep_type_t  ep_type     [NUM_EP],
	input wire logic [NUM_EP-1:0] ep_is_in,
	input wire logic [1:0]    ready_banks [NUM_EP],
	input wire uec_evt_t      ep_evt      [NUM_EP],
	input wire uec_cmd_t      ep_cmd      [NUM_EP]
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wr = psel && penable && pwrite;
	wire logic st = wr && paddr == `UEC_SET_BASE && pstrb == 4'hF;
	a_hold0_set: assert property (st && pwdata[24] |=> ep_cmd[0].hold0)
		else $error("bank zero hold missing");
	a_hold1_set: assert property (st && pwdata[25] |=> ep_cmd[0].hold1)
		else $error("bank one hold missing");
	a_hold0_clr: assert property (wr && paddr == `UEC_CLR_BASE && pstrb[3] && pwdata[24]
		|=> !ep_cmd[0].hold0)
		else $error("bank zero hold not cleared");
	a_halt_setup: assert property (ep_evt[0].setup_rx |=> ##1 !ep_cmd[0].halt_req)
		else $error("halt kept after setup");
	a_toggle_cmd: assert property (st && pwdata[18] |-> ep_cmd[0].toggle_clear)
		else $error("toggle clear missing");
	a_toggle_pulse: assert property (ep_cmd[0].toggle_clear |=> !ep_cmd[0].toggle_clear)
		else $error("toggle clear too long");
	a_bit18_zero: assert property (psel && penable && !pwrite && pready |-> !prdata[18])
		else $error("toggle bit read as one");
	a_discard_dec: assert property (ep_evt[0].discard_done |-> ##[0:1] ep_cmd[0].count_dec)
		else $error("count not decremented");
	a_irq_quiet: assert property ((ep_evt[0].event_flags == 7'h00)[*2] |-> !ep_cmd[0].irq)
		else $error("irq without event");
	a_ctrl_ro: assert property (wr && paddr == `UEC_CTRL_BASE |-> pready && pslverr)
		else $error("control write not refused");
	cover property (st && pwdata[13]);
	cover property (ep_evt[0].discard_done);
	cover property (ep_cmd[0].irq);
endmodule
bind uec_endpoint_control uec_properties #(.NUM_EP(NUM_EP)) u_props (.*);

// ==== testbench/uec_engine_model.sv ====
// Behavioural USB engine facing endpoint zero; the rest are idle control endpoints.
module uec_engine_model (
	// Clock, reset and bench requests.
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          setup_req,
	input wire logic [6:0]    flags,
	// Block side.
	input wire uec_pkg::uec_cmd_t ep_cmd [7],
	output uec_pkg::uec_ep_type_t ep_type [7],
	output logic [6:0]        ep_is_in,
	output logic [1:0]        ready_banks [7],
	output uec_pkg::uec_evt_t ep_evt [7]
);
	import uec_pkg::*;
	logic [1:0] kill_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			kill_q <= 2'h0;
		else
			kill_q <= {kill_q[0], ep_cmd[0].discard_start};
	end
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			ep_type[i] = (i == 0) ? UEC_EP_BULK : UEC_EP_CONTROL;
			ready_banks[i] = (i == 0) ? 2'h2 : 2'h0;
			ep_evt[i] = '0;
		end
		ep_is_in = 7'h01;
		ep_evt[0].setup_rx = setup_req;
		ep_evt[0].event_flags = flags;
		// Two banks wait; the model raises discard_done two cycles after discard_start and never raises discard_sent.
		ep_evt[0].discard_done = kill_q[1];
	end
endmodule

// ==== testbench/uec_endpoint_control_test.sv ====
// Directed register tests for the endpoint control block.
`include "uec_defines.svh"
module uec_endpoint_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import uec_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, setup_req = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, se;
	logic [6:0] flags = 7'h00, ep_is_in;
	uec_ep_type_t ep_type [7];
	logic [1:0] ready_banks [7];
	uec_evt_t ep_evt [7];
	uec_cmd_t ep_cmd [7];
	int err_count = 0, n_tests = 0;
	always #12.5 pclk = ~pclk;
	uec_endpoint_control #(.NUM_EP(7)) dut (.*);
	uec_engine_model eng (.*);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k == 16) begin
			err_count++;
			summarize();
		end
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		int k;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `UEC_CTRL_BASE, 32'h0);
		chk(rv, `UEC_CTRL_RESET);
		apb(1'b1, `UEC_SET_BASE, 32'h030C185F);
		@(posedge pclk);
		chk({29'h0, ep_cmd[0].hold0, ep_cmd[0].hold1, ep_cmd[0].halt_req}, 32'h7);
		apb(1'b0, `UEC_CTRL_BASE, 32'h0);
		chk(rv, 32'h0308185F);
		apb(1'b1, `UEC_CLR_BASE, 32'h01000001);
		apb(1'b0, `UEC_CTRL_BASE, 32'h0);
		chk(rv, 32'h0208185E);
		$display("set and clear test done");
		setup_req <= 1'b1;
		@(posedge pclk);
		setup_req <= 1'b0;
		apb(1'b0, `UEC_CTRL_BASE, 32'h0);
		chk(rv, 32'h0200185E);
		apb(1'b1, `UEC_SET_BASE + `UEC_EP_STRIDE, 32'h00000010);
		apb(1'b0, `UEC_CTRL_BASE + `UEC_EP_STRIDE, 32'h0);
		chk(rv, 32'h00000010);
		apb(1'b1, `UEC_SET_BASE + `UEC_EP_STRIDE, 32'h00002000);
		apb(1'b0, `UEC_CTRL_BASE + `UEC_EP_STRIDE, 32'h0);
		chk(rv, 32'h00000010);
		$display("setup and stride test done");
		apb(1'b1, `UEC_SET_BASE, 32'h00002000);
		for (k = 0; k < 16; k++) begin
			apb(1'b0, `UEC_CTRL_BASE, 32'h0);
			if (rv[13] === 1'b0)
				break;
		end
		chk(rv, 32'h0200185E);
		apb(1'b1, `UEC_CTRL_BASE, 32'hFFFFFFFF);
		chk({31'h0, se}, 32'h1);
		$display("discard and refusal test done");
		flags <= 7'h01;
		repeat (3) @(posedge pclk);
		chk({31'h0, ep_cmd[0].irq}, 32'h0);
		apb(1'b1, `UEC_SET_BASE, 32'h00000001);
		repeat (3) @(posedge pclk);
		chk({31'h0, ep_cmd[0].irq}, 32'h1);
		$display("interrupt gate test done");
		summarize();
	end
endmodule
